// ---- include/light_channel_pkg.sv ----
// Purpose: Shared constants and types for the light channel control block
// Assumes: 10 MHz system clock, AXI4-Lite register access with 32-bit data
// Notes: Currents are in mA, monitor levels in mV
package light_channel_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_SETPOINT = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_SEQ = 8'h0c;
	localparam logic [7:0] OFF_CLEAR = 8'h10;
	localparam logic [7:0] OFF_STEP = 8'h14;
	// Control field positions
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_GATED = 3;
	localparam int CTRL_TMODE_LSB = 4;
	localparam int CTRL_REPEAT = 6;
	localparam int CTRL_DIG_MON = 7;
	localparam int CTRL_LOW_POWER = 8;
	localparam int CTRL_OVERDRIVE = 9;
	localparam int CTRL_MANUAL_ON = 10;
	localparam int CTRL_W = 11;
	localparam logic [10:0] CTRL_RESET = 11'h000;
	localparam logic [15:0] SETPOINT_RESET = 16'h0000;
	localparam logic [15:0] SEQ_LEN_RESET = 16'h0000;
	localparam logic [15:0] SEQ_ON_RESET = 16'h0000;
	// Channel modes
	localparam logic [2:0] MODE_CONST = 3'h0;
	localparam logic [2:0] MODE_EXT_DIG = 3'h1;
	localparam logic [2:0] MODE_EXT_ANALOG = 3'h2;
	localparam logic [2:0] MODE_SQUARE = 3'h3;
	localparam logic [2:0] MODE_COMPLEX = 3'h4;
	localparam logic [2:0] MODE_CUSTOM = 3'h5;
	// Trigger modes
	localparam logic [1:0] TMODE_UNINT = 2'h0;
	localparam logic [1:0] TMODE_PAUSE = 2'h1;
	localparam logic [1:0] TMODE_CONT = 2'h2;
	localparam logic [1:0] TMODE_RESTART = 2'h3;
	// Current scaling
	localparam logic [15:0] NORMAL_MAX_MA = 16'h07d0;
	localparam logic [15:0] OVERDRIVE_MAX_MA = 16'h0fa0;
	localparam logic [15:0] LOW_POWER_DIV = 16'h000a;
	localparam logic [15:0] MON_HIGH_MV = 16'h1388;
	localparam logic [18:0] MV_PER_MA_X2 = 19'h0_0005;
	// Sequence step timing
	localparam int CLK_MHZ = 10;
	localparam int STEP_TIME_US = 1000;
	localparam int STEP_CYCLES = STEP_TIME_US * CLK_MHZ;
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Channel sequence states
	typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_PAUSED, ST_BLANK, ST_DONE} chan_state_e;
endpackage

// ---- hw/trigger_edge_detect.sv ----
// Purpose: Synchronise the trigger input and flag its edges
// Assumes: Trigger level holds for at least two clock cycles
// Notes: First stage feeds the second stage and the edge flags
`timescale 1ns/10ps
module trigger_edge_detect (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic trig_in,
	output logic level,
	output logic rise,
	output logic fall
);
	logic meta;
	logic prev;

	// Two-stage synchroniser, edges from both stages, then one delay stage
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta <= 1'b0;
			level <= 1'b0;
			prev <= 1'b0;
			rise <= 1'b0;
			fall <= 1'b0;
		end else begin
			meta <= trig_in;
			level <= meta;
			prev <= level;
			rise <= meta & ~level;
			fall <= ~meta & level;
		end
	end

	// Edge pulses last one cycle
	a_rise_single: assert property (@(posedge aclk) disable iff (!aresetn) rise |=> !rise)
		else $error("rise pulse longer than one cycle");
	a_fall_level: assert property (@(posedge aclk) disable iff (!aresetn) fall |-> !level ##1 !prev)
		else $error("fall pulse not matched by level");
endmodule // trigger_edge_detect

// ---- hw/light_channel_trigger_control.sv ----
// Purpose: Channel mode, trigger sequencing and current scaling for a light driver
// Assumes: Registers over AXI4-Lite, trigger and analog inputs synchronous-safe
// Notes: Waveform detail reduced to a step counter with an on-window
// Function
// - Triggered type stops on next rising edge; gated type stops on falling edge.
// - Uninterrupted mode starts on high level and ignores triggers while running.
// - With repeat, a finished sequence restarts on the next trigger pulse.
// - Uninterrupted mode is allowed with triggered type only.
// - Pause mode freezes on stop event and resumes on next rising edge.
// - Continue mode blanks output on stop event while step timing advances.
// - Restart mode stops on stop event and restarts from step zero.
// - Restart mode relaunches a completed sequence on the next trigger pulse.
// - Unsupported trigger mode and type combinations are rejected, not applied.
// - Digital monitor drives 5 V whenever drive current is above zero.
// - Low power divides current by ten; monitor keeps 400 mA/V scale.
// - External analog mode pins setpoint at maximum and ignores setpoint writes.
// - Constant mode drives setpoint, starts manually only, shows its indicator.
// - External digital mode follows trigger input and shows its indicator.
// - Non-sequence modes ignore all sequence parameters.
// - Six channel modes are selectable.
// - Overdrive on a compatible source lifts the normal current limit.
//
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
module light_channel_trigger_control #(
	parameter int STEP_CYCLES = light_channel_pkg::STEP_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic trig_in,
	input wire logic [15:0] analog_in_ma,
	input wire logic overdrive_capable,
	output logic light_on,
	output logic [15:0] drive_current_ma,
	output logic [15:0] monitor_mv,
	output logic monitor_digital,
	output logic constant_output_indicator,
	output logic external_digital_follow_indicator
);
	// Register state
	logic [10:0] ctrl;
	logic [15:0] setpoint;
	logic [15:0] seq_len;
	logic [15:0] seq_on;
	logic cfg_error;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic aw_held;
	logic w_held;
	// Sequence state
	light_channel_pkg::chan_state_e state;
	light_channel_pkg::chan_state_e next_state;
	logic [15:0] step;
	logic [15:0] next_step;
	logic [15:0] div_cnt;
	logic tick;
	logic trig_level;
	logic trig_rise;
	logic trig_fall;

	// Byte-lane merge for partial writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction

	trigger_edge_detect u_edge (
		.aclk(aclk),
		.aresetn(aresetn),
		.trig_in(trig_in),
		.level(trig_level),
		.rise(trig_rise),
		.fall(trig_fall)
	);

	// Control field decode
	wire [2:0] mode = ctrl[light_channel_pkg::CTRL_MODE_LSB +: 3];
	wire gated = ctrl[light_channel_pkg::CTRL_GATED];
	wire [1:0] tmode = ctrl[light_channel_pkg::CTRL_TMODE_LSB +: 2];
	wire repeat_en = ctrl[light_channel_pkg::CTRL_REPEAT];
	wire dig_mon = ctrl[light_channel_pkg::CTRL_DIG_MON];
	wire low_power = ctrl[light_channel_pkg::CTRL_LOW_POWER];
	wire overdrive = ctrl[light_channel_pkg::CTRL_OVERDRIVE] & overdrive_capable;
	wire manual_on = ctrl[light_channel_pkg::CTRL_MANUAL_ON];
	wire seq_mode = (mode >= light_channel_pkg::MODE_SQUARE) && (mode <= light_channel_pkg::MODE_CUSTOM);

	// Write path decode
	wire wr_fire = aw_held & w_held & ~s_axi_bvalid;
	wire wr_ctrl = aw_addr == light_channel_pkg::OFF_CTRL;
	wire wr_set = aw_addr == light_channel_pkg::OFF_SETPOINT;
	wire wr_seq = aw_addr == light_channel_pkg::OFF_SEQ;
	wire wr_clr = aw_addr == light_channel_pkg::OFF_CLEAR;
	wire wr_map = wr_ctrl | wr_set | wr_seq | wr_clr | (aw_addr == light_channel_pkg::OFF_STATUS)
		| (aw_addr == light_channel_pkg::OFF_STEP);
	wire [31:0] ctrl_merged = merge({21'h00_0000, ctrl}, w_data, w_strb);
	wire [31:0] set_merged = merge({16'h0000, setpoint}, w_data, w_strb);
	wire [31:0] seq_merged = merge({seq_on, seq_len}, w_data, w_strb);
	wire [1:0] new_tmode = ctrl_merged[light_channel_pkg::CTRL_TMODE_LSB +: 2];
	wire new_gated = ctrl_merged[light_channel_pkg::CTRL_GATED];
	wire [2:0] new_mode = ctrl_merged[light_channel_pkg::CTRL_MODE_LSB +: 3];
	wire ctrl_ok = !((new_tmode == light_channel_pkg::TMODE_UNINT) && new_gated)
		&& (new_mode <= light_channel_pkg::MODE_CUSTOM);
	wire ctrl_write = wr_fire & wr_ctrl & ctrl_ok;
	wire ctrl_reject = wr_fire & wr_ctrl & ~ctrl_ok;
	wire clr_error = wr_fire & wr_clr & w_strb[0] & w_data[0];

	// Write address and data capture, either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Write response and register update
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= light_channel_pkg::RESP_OKAY;
			ctrl <= light_channel_pkg::CTRL_RESET;
			setpoint <= light_channel_pkg::SETPOINT_RESET;
			seq_len <= light_channel_pkg::SEQ_LEN_RESET;
			seq_on <= light_channel_pkg::SEQ_ON_RESET;
			cfg_error <= 1'b0;
		end else begin
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (!wr_map || ctrl_reject) ? light_channel_pkg::RESP_SLVERR : light_channel_pkg::RESP_OKAY;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (ctrl_write) begin
				ctrl <= ctrl_merged[light_channel_pkg::CTRL_W-1:0];
			end
			if (mode == light_channel_pkg::MODE_EXT_ANALOG) begin
				setpoint <= light_channel_pkg::NORMAL_MAX_MA;
			end else if (wr_fire && wr_set) begin
				setpoint <= set_merged[15:0];
			end
			if (wr_fire && wr_seq) begin
				{seq_on, seq_len} <= seq_merged;
			end
			// Set wins over clear
			cfg_error <= ctrl_reject | (cfg_error & ~clr_error);
		end
	end

	// Read data select
	wire [7:0] status_bits = {cfg_error, external_digital_follow_indicator, constant_output_indicator, trig_level,
		light_on, state};
	wire [31:0] rd_word = (s_axi_araddr == light_channel_pkg::OFF_CTRL) ? {21'h00_0000, ctrl} :
		(s_axi_araddr == light_channel_pkg::OFF_SETPOINT) ? {16'h0000, setpoint} :
		(s_axi_araddr == light_channel_pkg::OFF_STATUS) ? {drive_current_ma, 8'h00, status_bits} :
		(s_axi_araddr == light_channel_pkg::OFF_SEQ) ? {seq_on, seq_len} :
		(s_axi_araddr == light_channel_pkg::OFF_STEP) ? {16'h0000, step} : 32'h0000_0000;
	wire rd_map = (s_axi_araddr == light_channel_pkg::OFF_CTRL) || (s_axi_araddr == light_channel_pkg::OFF_SETPOINT)
		|| (s_axi_araddr == light_channel_pkg::OFF_STATUS) || (s_axi_araddr == light_channel_pkg::OFF_SEQ)
		|| (s_axi_araddr == light_channel_pkg::OFF_STEP) || (s_axi_araddr == light_channel_pkg::OFF_CLEAR);

	// Read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= light_channel_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_map ? light_channel_pkg::RESP_OKAY : light_channel_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
		end
	end

	// Step timebase divider
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_cnt <= 16'h0000;
			tick <= 1'b0;
		end else begin
			tick <= div_cnt == 16'(STEP_CYCLES - 1);
			div_cnt <= (div_cnt == 16'(STEP_CYCLES - 1)) ? 16'h0000 : div_cnt + 16'h0001;
		end
	end

	// Sequence event decode
	wire stop_ev = gated ? trig_fall : trig_rise;
	wire step_last = (seq_len != 16'h0000) && (step == seq_len - 16'h0001);
	wire unint = tmode == light_channel_pkg::TMODE_UNINT;
	wire start_ev = unint ? trig_level : trig_rise;
	wire relaunch = repeat_en | (tmode == light_channel_pkg::TMODE_RESTART);
	wire [15:0] step_inc = tick ? step + 16'h0001 : step;

	// Sequence state machine
	always_comb begin
		next_state = state;
		next_step = step;
		if (!seq_mode || ctrl_write) begin
			next_state = light_channel_pkg::ST_IDLE;
			next_step = 16'h0000;
		end else begin
			case (state)
				light_channel_pkg::ST_IDLE: begin
					if (start_ev) begin
						next_state = light_channel_pkg::ST_RUN;
						next_step = 16'h0000;
					end
				end
				light_channel_pkg::ST_RUN: begin
					if (tick && step_last) begin
						next_state = light_channel_pkg::ST_DONE;
					end else if (!unint && stop_ev) begin
						case (tmode)
							light_channel_pkg::TMODE_PAUSE: next_state = light_channel_pkg::ST_PAUSED;
							light_channel_pkg::TMODE_CONT: begin
								next_state = light_channel_pkg::ST_BLANK;
								next_step = step_inc;
							end
							default: begin
								next_state = light_channel_pkg::ST_IDLE;
								next_step = 16'h0000;
							end
						endcase
					end else begin
						next_step = step_inc;
					end
				end
				light_channel_pkg::ST_PAUSED: begin
					if (trig_rise) begin
						next_state = light_channel_pkg::ST_RUN;
					end
				end
				light_channel_pkg::ST_BLANK: begin
					if (tick && step_last) begin
						next_state = light_channel_pkg::ST_DONE;
					end else begin
						next_step = step_inc;
						if (trig_rise) begin
							next_state = light_channel_pkg::ST_RUN;
						end
					end
				end
				light_channel_pkg::ST_DONE: begin
					if (trig_rise && relaunch) begin
						next_state = light_channel_pkg::ST_RUN;
						next_step = 16'h0000;
					end
				end
				default: next_state = light_channel_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= light_channel_pkg::ST_IDLE;
			step <= 16'h0000;
		end else begin
			state <= next_state;
			step <= next_step;
		end
	end

	// Output enable per mode
	wire seq_light = (state == light_channel_pkg::ST_RUN) && (step < seq_on);
	wire next_light = (mode == light_channel_pkg::MODE_CONST) ? manual_on :
		(mode == light_channel_pkg::MODE_EXT_DIG) ? trig_level :
		(mode == light_channel_pkg::MODE_EXT_ANALOG) ? 1'b1 : seq_light;
	// Current scaling and limiting
	wire [15:0] base_ma = (mode == light_channel_pkg::MODE_EXT_ANALOG) ? analog_in_ma : setpoint;
	wire [15:0] scaled_ma = low_power ? base_ma / light_channel_pkg::LOW_POWER_DIV : base_ma;
	wire [15:0] limit_ma = overdrive ? light_channel_pkg::OVERDRIVE_MAX_MA :
		low_power ? light_channel_pkg::NORMAL_MAX_MA / light_channel_pkg::LOW_POWER_DIV :
		light_channel_pkg::NORMAL_MAX_MA;
	wire [15:0] next_drive = !next_light ? 16'h0000 : (scaled_ma > limit_ma) ? limit_ma : scaled_ma;
	wire [18:0] mv_x2 = {3'h0, next_drive} * light_channel_pkg::MV_PER_MA_X2;
	wire next_mon_dig = next_drive != 16'h0000;
	wire [15:0] next_mon = dig_mon ? (next_mon_dig ? light_channel_pkg::MON_HIGH_MV : 16'h0000) : mv_x2[16:1];

	// Registered outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			light_on <= 1'b0;
			drive_current_ma <= 16'h0000;
			monitor_mv <= 16'h0000;
			monitor_digital <= 1'b0;
			constant_output_indicator <= 1'b0;
			external_digital_follow_indicator <= 1'b0;
		end else begin
			light_on <= next_light;
			drive_current_ma <= next_drive;
			monitor_mv <= next_mon;
			monitor_digital <= dig_mon & next_mon_dig;
			constant_output_indicator <= mode == light_channel_pkg::MODE_CONST;
			external_digital_follow_indicator <= mode == light_channel_pkg::MODE_EXT_DIG;
		end
	end

	a_analog_setpoint: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode == light_channel_pkg::MODE_EXT_ANALOG) |=> (setpoint == light_channel_pkg::NORMAL_MAX_MA))
		else $error("setpoint not pinned in analog mode");
	a_unint_ignore: assert property (@(posedge aclk) disable iff (!aresetn)
		(state == light_channel_pkg::ST_RUN) && unint && trig_rise && !ctrl_write && seq_mode
		|=> (state == light_channel_pkg::ST_RUN) || (state == light_channel_pkg::ST_DONE))
		else $error("uninterrupted run disturbed by trigger");
	a_gated_stop: assert property (@(posedge aclk) disable iff (!aresetn)
		(state == light_channel_pkg::ST_RUN) && gated && trig_fall && !unint |=> (state != light_channel_pkg::ST_RUN))
		else $error("gated sequence not stopped by falling edge");
	a_pause_freeze: assert property (@(posedge aclk) disable iff (!aresetn)
		(state == light_channel_pkg::ST_PAUSED) && ($past(state) == light_channel_pkg::ST_PAUSED) |-> $stable(step))
		else $error("step moved while paused");
	a_blank_dark: assert property (@(posedge aclk) disable iff (!aresetn)
		(state == light_channel_pkg::ST_BLANK) && seq_mode |=> !light_on && (drive_current_ma == 16'h0000))
		else $error("output on while blanked");
	a_restart_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		(state == light_channel_pkg::ST_RUN) && ($past(state) != light_channel_pkg::ST_RUN)
		&& ($past(state) != light_channel_pkg::ST_PAUSED) && ($past(state) != light_channel_pkg::ST_BLANK)
		|-> (step == 16'h0000))
		else $error("fresh start not at step zero");
	a_current_limit: assert property (@(posedge aclk) disable iff (!aresetn)
		##1 (drive_current_ma <= $past(limit_ma)))
		else $error("drive current above limit");
	a_digital_mon: assert property (@(posedge aclk) disable iff (!aresetn)
		monitor_digital |-> (monitor_mv == light_channel_pkg::MON_HIGH_MV) && (drive_current_ma != 16'h0000))
		else $error("digital monitor inconsistent with drive");
	a_const_manual: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode == light_channel_pkg::MODE_CONST) && !manual_on |=> !light_on)
		else $error("constant mode lit without manual start");
	a_no_gated_unint: assert property (@(posedge aclk) disable iff (!aresetn)
		!(unint && gated))
		else $error("uninterrupted mode with gated type");
endmodule // light_channel_trigger_control

// ---- testbench/trigger_source.sv ----
// Purpose: Trigger source model driving the channel trigger input
// Assumes: Level requests come from the bench
// Notes: Each level is held at least HOLD clocks, larger HOLD acts slower
`timescale 1ns/10ps
module trigger_source #(
	parameter int HOLD = 2
) (
	input wire logic aclk,
	input wire logic want,
	output logic trig_in
);
	int cnt = 0;
	initial trig_in = 1'b0;
	// Follow the request, never before the hold time ran out
	always @(posedge aclk) begin
		if (trig_in != want && cnt >= HOLD - 1) begin
			trig_in <= want;
			cnt <= 0;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule // trigger_source

// ---- testbench/tb.sv ----
// Purpose: Self-checking bench for the light channel control block
// Assumes: STEP_CYCLES of 4, trigger model holding levels 3 clocks
// Notes: Registers reached through AXI4-Lite tasks
`timescale 1ns/10ps
module tb;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, want, trig, od_cap;
	logic awready, wready, bvalid, arready, rvalid, light_on, mon_dig, c_ind, x_ind;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, seed, sp, t;
	logic [1:0] bresp, rresp, r;
	logic [15:0] drive, mon_mv, ana;
	int bad_count = 0;
	int n_checks = 0;
	int tms[4] = '{0, 0, 3, 1};
	int rps[4] = '{1, 0, 0, 1};
	int exs[4] = '{1, 4, 1, 1};
	light_channel_trigger_control #(.STEP_CYCLES(4)) DUT (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.trig_in(trig), .analog_in_ma(ana), .overdrive_capable(od_cap), .light_on(light_on),
		.drive_current_ma(drive), .monitor_mv(mon_mv), .monitor_digital(mon_dig),
		.constant_output_indicator(c_ind), .external_digital_follow_indicator(x_ind));
	trigger_source #(.HOLD(3)) src (.aclk(aclk), .want(want), .trig_in(trig));
	// Clock
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [31:0] cf(input logic [2:0] m, input logic g, input logic [1:0] tm, input logic rp);
		cf = {25'h0, rp, tm, g, m};
	endfunction
	// Expected drive current from setpoint and options
	function automatic logic [31:0] ed(input logic [31:0] s, input logic lp, input logic od);
		logic [31:0] lim;
		lim = od ? light_channel_pkg::OVERDRIVE_MAX_MA : light_channel_pkg::NORMAL_MAX_MA;
		ed = (s > lim ? lim : s) / (lp ? 10 : 1);
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic finish_test;
		if (bad_count == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// Write cycle: address and data offered together, released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
		logic ah, wh, bh;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		bh = 1'b0;
		for (int n = 0; n < 50 && !bh; n++) begin
			@(negedge aclk);
			ah = awvalid & awready;
			wh = wvalid & wready;
			bh = bvalid;
			resp = bresp;
			@(posedge aclk);
			if (ah) awvalid <= 1'b0;
			if (wh) wvalid <= 1'b0;
		end
		bready <= 1'b0;
		if (!bh) chk(0, 1);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		logic ah, rh;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		rh = 1'b0;
		for (int n = 0; n < 50 && !rh; n++) begin
			@(negedge aclk);
			ah = arvalid & arready;
			rh = rvalid;
			d = rdata;
			resp = rresp;
			@(posedge aclk);
			if (ah) arvalid <= 1'b0;
		end
		rready <= 1'b0;
		if (!rh) chk(0, 1);
	endtask
	task automatic wc(input logic [31:0] d, input logic [1:0] e);
		wr(light_channel_pkg::OFF_CTRL, d, r);
		chk(r, e);
	endtask
	task automatic st(input logic [2:0] e);
		rd(light_channel_pkg::OFF_STATUS, t, r);
		chk(t[2:0], e);
	endtask
	task automatic pulse;
		want <= 1'b1;
		tick(10);
		want <= 1'b0;
		tick(10);
	endtask
	task automatic sq(input logic [1:0] tm, input logic g, input logic rp, input logic [15:0] len);
		wr(light_channel_pkg::OFF_SEQ, {16'hffff, len}, r);
		wc(cf(3'h3, g, tm, rp), 2'h0);
	endtask
	// Watchdog
	initial begin
		tick(20000);
		bad_count++;
		finish_test();
	end
	// Main sequence
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, want, od_cap} = 8'h00;
		{awaddr, araddr, wdata, ana} = 64'h0;
		seed = 32'h0000_fd7c;
		tick(8);
		aresetn <= 1'b1;
		tick(2);
		chk(c_ind, 1);
		rd(light_channel_pkg::OFF_CTRL, t, r);
		chk(t, 0);
		for (int i = 0; i < 3; i++) begin
			seed = lfsr(seed);
			sp = seed % 2000 + 1;
			wr(light_channel_pkg::OFF_SETPOINT, sp, r);
			wc(32'h0000_0400, 2'h0);
			tick(4);
			chk(drive, sp);
			chk(mon_mv, sp * 5 / 2);
			pulse();
			chk(light_on, 1);
			wc(32'h0000_0480, 2'h0);
			tick(4);
			chk(mon_dig, 1);
			chk(mon_mv, light_channel_pkg::MON_HIGH_MV);
			wc(32'h0000_0500, 2'h0);
			tick(4);
			chk(drive, ed(sp, 1, 0));
			chk(mon_mv, ed(sp, 1, 0) * 5 / 2);
		end
		wr(light_channel_pkg::OFF_SETPOINT, 32'h0000_0bb8, r);
		wc(32'h0000_0600, 2'h0);
		for (int c = 1; c >= 0; c--) begin
			od_cap <= c[0];
			tick(4);
			chk(drive, ed(32'h0000_0bb8, 0, c[0]));
		end
		wc(cf(3'h1, 0, 0, 0), 2'h0);
		tick(4);
		chk(x_ind, 1);
		want <= 1'b1;
		tick(10);
		chk(light_on, 1);
		want <= 1'b0;
		tick(10);
		chk(light_on, 0);
		seed = lfsr(seed);
		ana <= seed % 2000;
		wc(cf(3'h2, 0, 0, 0), 2'h0);
		wr(light_channel_pkg::OFF_SETPOINT, 32'h0000_0005, r);
		rd(light_channel_pkg::OFF_SETPOINT, t, r);
		chk(t, light_channel_pkg::NORMAL_MAX_MA);
		chk(drive, ana);
		for (int m = 0; m < 8; m++) wc(cf(m[2:0], 0, 1, 0), m > 5 ? 2'h2 : 2'h0);
		wc(cf(3'h3, 1, 0, 1), 2'h2);
		st(3'h0);
		chk(t[7], 1);
		wc(cf(3'h3, 1, 3, 1), 2'h0);
		rd(8'h20, t, r);
		chk(t, 32'h0000_0000);
		chk(r, 2'h2);
		sq(3, 0, 0, 0);
		pulse();
		st(3'h1);
		chk(light_on, 1);
		pulse();
		st(3'h0);
		chk(light_on, 0);
		pulse();
		st(3'h1);
		sq(1, 1, 0, 0);
		want <= 1'b1;
		tick(10);
		st(3'h1);
		want <= 1'b0;
		tick(10);
		st(3'h2);
		rd(light_channel_pkg::OFF_STEP, sp, r);
		tick(12);
		rd(light_channel_pkg::OFF_STEP, t, r);
		chk(t, sp);
		want <= 1'b1;
		tick(10);
		st(3'h1);
		want <= 1'b0;
		sq(2, 0, 0, 0);
		pulse();
		pulse();
		st(3'h3);
		chk(light_on, 0);
		rd(light_channel_pkg::OFF_STEP, sp, r);
		tick(12);
		rd(light_channel_pkg::OFF_STEP, t, r);
		chk(t != sp, 1);
		pulse();
		st(3'h1);
		sq(0, 0, 0, 0);
		pulse();
		pulse();
		st(3'h1);
		for (int i = 0; i < 4; i++) begin
			// Sixteen steps outlast the relaunch pulse, so a relaunched run is still seen running
			sq(tms[i][1:0], 0, rps[i][0], 16'h0010);
			pulse();
			tick(80);
			st(3'h4);
			pulse();
			st(exs[i][2:0]);
		end
		finish_test();
	end
endmodule // tb
